/* rtl/host_uart_defs.svh */
`ifndef HOST_UART_DEFS_SVH
`define HOST_UART_DEFS_SVH
// Register byte offsets.
`define OFF_CTRL        8'h00
`define OFF_BAUD        8'h04
`define OFF_BRK_TIMEOUT 8'h08
`define OFF_TXDATA      8'h0C
`define OFF_RXDATA      8'h10
`define OFF_STATUS      8'h14
`define OFF_IRQ_STAT    8'h18
`define OFF_IRQ_CLR     8'h1C
`define OFF_IRQ_EN      8'h20
// Control field positions.
`define CTRL_PAR_LO     0
`define CTRL_TWO_STOP   2
`define CTRL_FLOW_EN    3
`define CTRL_SEND_BRK   4
`define CTRL_BYPASS     5
// Parity encodings.
`define PAR_NONE        2'h0
`define PAR_ODD         2'h1
`define PAR_EVEN        2'h2
// Interrupt bit positions.
`define IRQ_RX_DONE     0
`define IRQ_TX_DONE     1
`define IRQ_BREAK       2
`define IRQ_PAR_ERR     3
`define IRQ_FRAME_ERR   4
`define IRQ_BITS        5
// Reset values.
`define BAUD_RESET      16'h01D8
`define BRK_TO_RESET    16'h0064
// Timing: rate = setting / 0.004096, i.e. 4096 ppm seconds.
`define CLK_HZ          50000000
`define CLK_NS          20
`define BAUD_DIV_PPM    4096
`define OVERSAMPLE      8
`define ACC_MOD         ((`CLK_HZ / 1000000) * `BAUD_DIV_PPM / `OVERSAMPLE)
`define MS_NS           1000000
`define BRK_MS_CYCLES   (`MS_NS / `CLK_NS)
// AXI responses.
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

/* rtl/host_uart_pkg.sv */
package host_uart_pkg;
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axi_rsp_t;

    typedef enum logic [2:0] {
        SER_IDLE  = 3'b000,
        SER_START = 3'b001,
        SER_DATA  = 3'b010,
        SER_PAR   = 3'b011,
        SER_STOP  = 3'b100
    } ser_state_t;
endpackage : host_uart_pkg

/* rtl/host_uart_with_bypass.sv */
`timescale 1ns/10ps
`include "host_uart_defs.svh"
// Functional notes
// - Data on one receive and one transmit line; flow lines active low.
// - Frame: parity none, odd or even; one or two stops; eight data bits.
// - Bit rate equals baud setting divided by 0.004096, 1200 to 4M baud.
// - Tabulated settings such as 0x0027 and 0x01D8 give standard rates.
// - Receive line low longer than the timeout resets the whole chip.
// - Device can send a break on its transmit line to wake the host.
// - All port outputs float while the chip is held in reset.
// - After reset the host lines connect to the internal port by default.
// - Bypass command routes host lines through general io lines 7 to 4.
// - After bypass the device sleeps deeply and keeps the path connected.
// - Only a chip reset leaves bypass and restores the direct connection.
module host_uart_with_bypass
    import host_uart_pkg::*;
#(
    parameter int MS_CYCLES = `BRK_MS_CYCLES
) (
    input  wire logic     ref_clk,       // System clock, 50 MHz.
    input  wire logic     rst,           // Synchronous reset, active high.
    input  wire axi_req_t axi_req,       // AXI4-Lite requests.
    output axi_rsp_t      axi_rsp,       // AXI4-Lite responses.
    input  wire logic     uart_rx_i,     // Host receive line.
    input  wire logic     uart_cts_n_i,  // Host clear-to-send, active low.
    output logic          uart_tx_o,     // Host transmit line.
    output logic          uart_tx_oe,    // Transmit line drive enable.
    output logic          uart_rts_n_o,  // Request-to-send, active low.
    output logic          uart_rts_n_oe, // Request-to-send drive enable.
    input  wire logic [3:0] gio_i,       // General io lines 7 to 4, input.
    output logic [3:0]    gio_o,         // General io lines 7 to 4, output.
    output logic [3:0]    gio_oe,        // General io lines 7 to 4, enable.
    output logic          irq,           // Level interrupt.
    output logic          chip_reset_req,// Break-reset request to the chip.
    output logic          deep_sleep     // Deep sleep indication.
);
    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        axi_rsp_t           rsp;
        logic               aw_full;
        logic               w_full;
        logic [7:0]         aw_addr;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic [1:0]         parity;
        logic               two_stop;
        logic               flow_en;
        logic               send_brk;
        logic               bypass;
        logic [15:0]        baud;
        logic [15:0]        brk_to;
        logic [`IRQ_BITS-1:0] irq_en;
        logic [`IRQ_BITS-1:0] irq_st;
        logic [1:0]         rx_sync;
        logic [1:0]         cts_sync;
        logic [1:0]         gtx_sync;
        logic [1:0]         grts_sync;
        logic [16:0]        acc;
        logic               tick;
        ser_state_t         tx_st;
        logic [7:0]         tx_sh;
        logic [2:0]         tx_bit;
        logic [2:0]         tx_sub;
        logic               tx_par;
        logic               tx_line;
        logic [7:0]         tx_buf;
        logic               tx_full;
        ser_state_t         rx_st;
        logic [7:0]         rx_sh;
        logic [2:0]         rx_bit;
        logic [2:0]         rx_sub;
        logic               rx_par;
        logic               rx_perr;
        logic [7:0]         rx_data;
        logic               rx_valid;
        logic [31:0]        brk_cyc;
        logic [15:0]        brk_ms;
        logic               tx_o;
        logic               tx_oe;
        logic               rts_n;
        logic               rts_oe;
        logic [3:0]         gio_o;
        logic [3:0]         gio_oe;
        logic               irq;
        logic               chip_rst;
        logic               sleep;
    } state_t;

    state_t s;
    state_t n;

    // Refuse a millisecond count that the counter cannot reach.
    if (MS_CYCLES < 1) begin : g_bad_ms
        $error("MS_CYCLES must be at least one");
    end

    // Merges the written byte lanes into a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        logic bit_in;
        logic [`IRQ_BITS-1:0] ev;
        logic [`IRQ_BITS-1:0] clr;
        logic rd_pop;
        bit_in = 1'b0;
        ev     = '0;
        clr    = '0;
        rd_pop = 1'b0;
        n      = s;
        // Two-flop synchronisers for the receive, clear-to-send and gio_i[1], gio_i[3] inputs.
        n.rx_sync   = {s.rx_sync[0], uart_rx_i};
        n.cts_sync  = {s.cts_sync[0], uart_cts_n_i};
        n.gtx_sync  = {s.gtx_sync[0], gio_i[1]};
        n.grts_sync = {s.grts_sync[0], gio_i[3]};

        // Bus: capture address and data in either order, answer after both.
        if (axi_req.awvalid && s.rsp.awready) begin
            n.aw_full = 1'b1;
            n.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s.rsp.wready) begin
            n.w_full = 1'b1;
            n.wdata  = axi_req.wdata;
            n.wstrb  = axi_req.wstrb;
        end
        if (s.rsp.bvalid && axi_req.bready) begin
            n.rsp.bvalid = 1'b0;
        end
        if (s.aw_full && s.w_full && !s.rsp.bvalid) begin
            n.aw_full    = 1'b0;
            n.w_full     = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp  = `RESP_OKAY;
            if (s.aw_addr == `OFF_CTRL) begin
                if (s.wstrb[0]) begin
                    n.parity   = s.wdata[`CTRL_PAR_LO+1:`CTRL_PAR_LO];
                    n.two_stop = s.wdata[`CTRL_TWO_STOP];
                    n.flow_en  = s.wdata[`CTRL_FLOW_EN];
                    n.send_brk = s.wdata[`CTRL_SEND_BRK];
                    // Bypass can only be set; only reset clears it.
                    n.bypass   = s.bypass | s.wdata[`CTRL_BYPASS];
                end
            end else if (s.aw_addr == `OFF_BAUD) begin
                n.baud = merge16(s.baud, s.wdata, s.wstrb);
            end else if (s.aw_addr == `OFF_BRK_TIMEOUT) begin
                n.brk_to = merge16(s.brk_to, s.wdata, s.wstrb);
            end else if (s.aw_addr == `OFF_TXDATA) begin
                // A write while the holding byte is full is dropped.
                if (s.wstrb[0] && !s.tx_full) begin
                    n.tx_buf  = s.wdata[7:0];
                    n.tx_full = 1'b1;
                end
            end else if (s.aw_addr == `OFF_IRQ_CLR) begin
                clr = s.wdata[`IRQ_BITS-1:0] & {`IRQ_BITS{s.wstrb[0]}};
            end else if (s.aw_addr == `OFF_IRQ_EN) begin
                if (s.wstrb[0]) begin
                    n.irq_en = s.wdata[`IRQ_BITS-1:0];
                end
            end else if (s.aw_addr == `OFF_RXDATA || s.aw_addr == `OFF_STATUS ||
                         s.aw_addr == `OFF_IRQ_STAT) begin
                n.rsp.bresp = `RESP_OKAY;
            end else begin
                n.rsp.bresp = `RESP_SLVERR;
            end
        end
        n.rsp.awready = !n.aw_full;
        n.rsp.wready  = !n.w_full;

        // Bus reads; reading the receive byte frees it.
        if (s.rsp.rvalid && axi_req.rready) begin
            n.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s.rsp.arready) begin
            n.rsp.rvalid = 1'b1;
            n.rsp.rresp  = `RESP_OKAY;
            n.rsp.rdata  = 32'h0000_0000;
            if (axi_req.araddr == `OFF_CTRL) begin
                n.rsp.rdata[5:0] = {s.bypass, s.send_brk, s.flow_en, s.two_stop, s.parity};
            end else if (axi_req.araddr == `OFF_BAUD) begin
                n.rsp.rdata[15:0] = s.baud;
            end else if (axi_req.araddr == `OFF_BRK_TIMEOUT) begin
                n.rsp.rdata[15:0] = s.brk_to;
            end else if (axi_req.araddr == `OFF_RXDATA) begin
                n.rsp.rdata[7:0] = s.rx_data;
                rd_pop = 1'b1;
            end else if (axi_req.araddr == `OFF_STATUS) begin
                n.rsp.rdata[3:0] = {s.bypass, s.rx_valid, s.tx_full, s.tx_st != SER_IDLE};
            end else if (axi_req.araddr == `OFF_IRQ_STAT) begin
                n.rsp.rdata[`IRQ_BITS-1:0] = s.irq_st;
            end else if (axi_req.araddr == `OFF_IRQ_EN) begin
                n.rsp.rdata[`IRQ_BITS-1:0] = s.irq_en;
            end else if (axi_req.araddr == `OFF_TXDATA || axi_req.araddr == `OFF_IRQ_CLR) begin
                n.rsp.rresp = `RESP_OKAY;
            end else begin
                n.rsp.rresp = `RESP_SLVERR;
            end
        end
        n.rsp.arready = !n.rsp.rvalid;

        // Phase accumulator gives eight ticks per bit at setting/0.004096.
        n.tick = 1'b0;
        if (s.acc + {1'b0, s.baud} >= 17'(`ACC_MOD)) begin
            n.acc  = s.acc + {1'b0, s.baud} - 17'(`ACC_MOD);
            n.tick = 1'b1;
        end else begin
            n.acc = s.acc + {1'b0, s.baud};
        end

        // Transmitter.
        case (s.tx_st)
            SER_IDLE: begin
                n.tx_line = !s.send_brk;
                if (s.tick && s.tx_full && !s.send_brk && !s.bypass &&
                    (!s.flow_en || !s.cts_sync[1])) begin
                    n.tx_st   = SER_START;
                    n.tx_line = 1'b0;
                    n.tx_sh   = s.tx_buf;
                    n.tx_full = 1'b0;
                    n.tx_sub  = 3'h0;
                    n.tx_bit  = 3'h0;
                    n.tx_par  = 1'b0;
                end
            end
            default: begin
                if (s.tick) begin
                    n.tx_sub = s.tx_sub + 3'h1;
                    if (s.tx_sub == 3'h7) begin
                        if (s.tx_st == SER_START) begin
                            n.tx_st   = SER_DATA;
                            n.tx_line = s.tx_sh[0];
                        end else if (s.tx_st == SER_DATA) begin
                            n.tx_par = s.tx_par ^ s.tx_sh[0];
                            n.tx_sh  = {1'b0, s.tx_sh[7:1]};
                            n.tx_bit = s.tx_bit + 3'h1;
                            n.tx_line = s.tx_sh[1];
                            if (s.tx_bit == 3'h7) begin
                                if (s.parity != `PAR_NONE) begin
                                    n.tx_st   = SER_PAR;
                                    n.tx_line = (s.tx_par ^ s.tx_sh[0]) ^ (s.parity == `PAR_ODD);
                                end else begin
                                    n.tx_st   = SER_STOP;
                                    n.tx_line = 1'b1;
                                end
                                n.tx_bit = 3'h0;
                            end
                        end else if (s.tx_st == SER_PAR) begin
                            n.tx_st   = SER_STOP;
                            n.tx_line = 1'b1;
                        end else if (s.two_stop && s.tx_bit == 3'h0) begin
                            n.tx_bit = 3'h1;
                        end else begin
                            n.tx_st = SER_IDLE;
                            ev[`IRQ_TX_DONE] = 1'b1;
                        end
                    end
                end
            end
        endcase

        // Receiver samples each bit at its middle tick.
        bit_in = s.rx_sync[1];
        case (s.rx_st)
            SER_IDLE: begin
                if (s.tick && !bit_in && !s.bypass) begin
                    n.rx_st  = SER_START;
                    n.rx_sub = 3'h0;
                end
            end
            SER_START: begin
                if (s.tick) begin
                    n.rx_sub = s.rx_sub + 3'h1;
                    if (s.rx_sub == 3'h3) begin
                        n.rx_st  = bit_in ? SER_IDLE : SER_DATA;
                        n.rx_sub = 3'h0;
                        n.rx_bit = 3'h0;
                        n.rx_par = 1'b0;
                    end
                end
            end
            default: begin
                if (s.tick) begin
                    n.rx_sub = s.rx_sub + 3'h1;
                    if (s.rx_sub == 3'h7) begin
                        if (s.rx_st == SER_DATA) begin
                            n.rx_sh  = {bit_in, s.rx_sh[7:1]};
                            n.rx_par = s.rx_par ^ bit_in;
                            n.rx_bit = s.rx_bit + 3'h1;
                            n.rx_perr = 1'b0;
                            if (s.rx_bit == 3'h7) begin
                                n.rx_st = (s.parity != `PAR_NONE) ? SER_PAR : SER_STOP;
                            end
                        end else if (s.rx_st == SER_PAR) begin
                            n.rx_perr = (s.rx_par ^ bit_in) ^ (s.parity == `PAR_ODD);
                            n.rx_st   = SER_STOP;
                        end else begin
                            n.rx_st = SER_IDLE;
                            if (!bit_in) begin
                                ev[`IRQ_FRAME_ERR] = 1'b1;
                                ev[`IRQ_BREAK]     = (s.rx_sh == 8'h00);
                            end else begin
                                n.rx_data          = s.rx_sh;
                                n.rx_valid         = 1'b1;
                                ev[`IRQ_RX_DONE]   = 1'b1;
                                ev[`IRQ_PAR_ERR]   = s.rx_perr;
                            end
                        end
                    end
                end
            end
        endcase
        if (rd_pop && !(ev[`IRQ_RX_DONE])) begin
            n.rx_valid = 1'b0;
        end

        // Break timer in milliseconds while the receive line stays low.
        if (!bit_in && !s.bypass) begin
            if (s.brk_cyc == 32'(MS_CYCLES - 1)) begin
                n.brk_cyc = 32'h0000_0000;
                if (s.brk_ms != 16'hFFFF) begin
                    n.brk_ms = s.brk_ms + 16'h0001;
                end
            end else begin
                n.brk_cyc = s.brk_cyc + 32'h0000_0001;
            end
        end else begin
            n.brk_cyc = 32'h0000_0000;
            n.brk_ms  = 16'h0000;
        end
        if (!s.bypass && s.brk_ms > s.brk_to) begin
            n.chip_rst = 1'b1;
        end

        // Sticky events: a new event wins over a clear in the same cycle.
        n.irq_st = (s.irq_st & ~clr) | ev;
        n.irq    = |(n.irq_st & n.irq_en);

        // Pins: direct connection by default, general io path in bypass.
        n.sleep  = n.bypass;
        n.tx_oe  = 1'b1;
        n.rts_oe = 1'b1;
        if (n.bypass) begin
            n.tx_o   = s.gtx_sync[1];
            n.rts_n  = s.grts_sync[1];
            n.gio_o  = {1'b0, s.cts_sync[1], 1'b0, s.rx_sync[1]};
            n.gio_oe = 4'h5;
        end else begin
            n.tx_o   = n.tx_line;
            n.rts_n  = s.flow_en ? n.rx_valid : 1'b0;
            n.gio_o  = 4'h0;
            n.gio_oe = 4'h0;
        end
    end

    // Registers the whole state; reset floats every pin.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s         <= '0;
            s.baud    <= `BAUD_RESET;
            s.brk_to  <= `BRK_TO_RESET;
            s.rx_sync <= 2'b11; // Line idles high, so no false start follows reset.
        end else begin
            s <= n;
        end
    end

    // Outputs straight from flip-flops.
    assign axi_rsp        = s.rsp;
    assign uart_tx_o      = s.tx_o;
    assign uart_tx_oe     = s.tx_oe;
    assign uart_rts_n_o   = s.rts_n;
    assign uart_rts_n_oe  = s.rts_oe;
    assign gio_o          = s.gio_o;
    assign gio_oe         = s.gio_oe;
    assign irq            = s.irq;
    assign chip_reset_req = s.chip_rst;
    assign deep_sleep     = s.sleep;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence seq_tx_launch;
        s.tx_st == SER_IDLE ##1 s.tx_st == SER_START;
    endsequence

    chk_float_reset: assert property (@(posedge ref_clk) rst |=> !uart_tx_oe && !uart_rts_n_oe)
        else $error("port drives during reset");
    chk_default_direct: assert property (@(posedge ref_clk) rst |=> !s.bypass && !gio_oe[0])
        else $error("bypass active after reset");
    chk_bypass_sticky: assert property (@(posedge ref_clk) disable iff (rst)
        s.bypass |=> s.bypass)
        else $error("bypass left without reset");
    chk_bypass_route: assert property (@(posedge ref_clk) disable iff (rst)
        s.bypass && $past(s.bypass) |-> uart_tx_o == $past(s.gtx_sync[1]))
        else $error("bypass path not forwarded");
    chk_sleep_bypass: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.bypass) |=> deep_sleep [*3])
        else $error("deep sleep missing in bypass");
    chk_start_low: assert property (@(posedge ref_clk) disable iff (rst)
        seq_tx_launch |-> !uart_tx_o ##1 !uart_tx_o)
        else $error("start bit not low");
    chk_break_send: assert property (@(posedge ref_clk) disable iff (rst)
        s.send_brk && !s.bypass && s.tx_st == SER_IDLE ##1 s.send_brk |-> !uart_tx_o)
        else $error("break not driven");
    chk_break_reset: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(chip_reset_req) |-> $past(s.brk_ms) > $past(s.brk_to))
        else $error("chip reset without long break");
    chk_rts_level: assert property (@(posedge ref_clk) disable iff (rst)
        !s.bypass && s.flow_en && s.rx_valid ##1 s.rx_valid |-> uart_rts_n_o)
        else $error("request-to-send low while full");
    chk_stop_high: assert property (@(posedge ref_clk) disable iff (rst)
        !s.bypass && s.tx_st == SER_STOP |-> uart_tx_o)
        else $error("stop bit not high");
endmodule : host_uart_with_bypass

/* bench/host_serial_model.sv */
`timescale 1ns/10ps
// ****************************************
// Host end of the serial link
// ****************************************
module host_serial_model #(
    parameter int BIT = 16              // Clock cycles per bit.
) (
    input  wire logic ref_clk,          // System clock.
    input  wire logic line_in,          // Device transmit line.
    output logic      line_out,         // Device receive line, idle high.
    output logic      clr_n             // Clear-to-send, active low.
);
    // The host drives the receive and clear-to-send lines, never the shared transmit line.
    // Line idles high and the host lets the device send.
    initial begin
        line_out = 1'b1;
        clr_n    = 1'b0;                // Low grants permission to send.
    end
    // Changes the clear-to-send level just after an edge.
    task automatic set_clr(input logic v);
        clr_n <= v;
    endtask : set_clr
    // Drives the receive line at one level for n cycles.
    task automatic hold(input logic v, input int n);
        line_out <= v;
        repeat (n) @(posedge ref_clk);
    endtask : hold
    // Sends a low start, data LSB first and a high stop.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) hold(f[i], BIT);
    endtask : send
    // Samples eleven bit times from the middle of the start bit.
    task automatic recv(output logic [10:0] f);
        do @(posedge ref_clk); while (line_in !== 1'b0);
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = line_in;
            repeat (BIT) @(posedge ref_clk);
        end
    endtask : recv
endmodule : host_serial_model

/* bench/host_uart_with_bypass_test.sv */
`timescale 1ns/10ps
`include "host_uart_defs.svh"
module host_uart_with_bypass_test import host_uart_pkg::*;;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    axi_req_t    req     = '0;
    axi_rsp_t    rsp;
    logic [3:0]  gio_i   = 4'h0;
    logic        rx, cts_n, tx, tx_oe, rts_n, rts_oe, irq, chip_rst, sleep;
    logic [3:0]  gio_o, gio_oe;
    logic [31:0] d;
    logic [1:0]  r;
    logic [10:0] f;
    logic [7:0]  b;
    int          num_errors = 0;
    int          tests_run  = 0;
    // Clock of 20 ns period.
    always #10 ref_clk = ~ref_clk;
    host_uart_with_bypass #(.MS_CYCLES(10)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .axi_req(req), .axi_rsp(rsp), .uart_rx_i(rx), .uart_cts_n_i(cts_n), .uart_tx_o(tx),
        .uart_tx_oe(tx_oe), .uart_rts_n_o(rts_n), .uart_rts_n_oe(rts_oe), .gio_i(gio_i),
        .gio_o(gio_o), .gio_oe(gio_oe), .irq(irq), .chip_reset_req(chip_rst), .deep_sleep(sleep));
    host_serial_model i_host (.ref_clk(ref_clk), .line_in(tx), .line_out(rx), .clr_n(cts_n));
    // ****************************************
    // Bus and checking tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Write with both channels offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b1;
        w  = 1'b1;
        @(posedge ref_clk);
        req.awaddr <= a; req.wdata <= v; req.wstrb <= 4'hF;
        req.awvalid <= 1'b1; req.wvalid <= 1'b1; req.bready <= 1'b1;
        while (aw || w) begin
            @(posedge ref_clk);
            if (aw && rsp.awready) begin req.awvalid <= 1'b0; aw = 1'b0; end
            if (w && rsp.wready) begin req.wvalid <= 1'b0; w = 1'b0; end
        end
        while (rsp.bvalid !== 1'b1) @(posedge ref_clk);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        @(posedge ref_clk);
        req.araddr <= a; req.arvalid <= 1'b1; req.rready <= 1'b1;
        do @(posedge ref_clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        while (rsp.rvalid !== 1'b1) @(posedge ref_clk);
        v = rsp.rdata;
        e = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0]  e;
        rd(a, v, e);
        chk(v, exp);
    endtask : rdchk
    // Holds reset for three cycles and looks at the drivers meanwhile.
    task automatic do_reset();
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(32'({tx_oe, rts_oe}), 32'h0);                  // Lines float in reset.
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : do_reset
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        do_reset();
        rdchk(`OFF_BAUD, 32'h0000_01D8);                   // Default baud setting.
        rdchk(`OFF_BRK_TIMEOUT, 32'h0000_0064);            // Default timeout.
        chk(32'({sleep, gio_oe, tx_oe}), 32'h1);           // Direct path by default.
        rd(8'h40, d, r);
        chk(32'(r), 32'(`RESP_SLVERR));
        wr(8'h40, 32'h0);
        chk(32'(r), 32'(`RESP_SLVERR));
        $display("test reset done");
        wr(`OFF_BAUD, 32'h0000_3200);
        for (int p = 0; p < 3; p++) begin
            b = 8'hA6 + 8'(p);
            wr(`OFF_CTRL, 32'(p));
            fork i_host.recv(f); wr(`OFF_TXDATA, 32'(b)); join
            chk(32'(f), 32'({1'b1, (p == 0) ? 1'b1 : ((p == 1) ? ~^b : ^b), b, 1'b0}));
        end
        wr(`OFF_CTRL, 32'h8);
        i_host.set_clr(1'b1);
        wr(`OFF_TXDATA, 32'h3C);
        repeat (40) @(posedge ref_clk);
        chk(32'(tx), 32'h1);                               // Held while not cleared.
        fork i_host.recv(f); i_host.set_clr(1'b0); join
        chk(32'(f), 32'h678);                              // Sent once cleared.
        $display("test transmit done");
        wr(`OFF_IRQ_EN, 32'h1);
        i_host.send(8'h5A);
        repeat (4) @(posedge ref_clk);
        chk(32'({irq, rts_n}), 32'h3);                     // Received, flow held off.
        rdchk(`OFF_RXDATA, 32'h5A);                        // Byte assembled.
        rd(`OFF_IRQ_STAT, d, r);
        chk(d & 32'h3, 32'h3);
        wr(`OFF_IRQ_CLR, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(32'({irq, rts_n}), 32'h0);                     // Cleared, flow open.
        $display("test receive done");
        wr(`OFF_CTRL, 32'h10);
        repeat (40) @(posedge ref_clk);
        chk(32'(tx), 32'h0);                               // Break on the line.
        wr(`OFF_BRK_TIMEOUT, 32'h2);
        i_host.hold(1'b0, 15);
        chk(32'(chip_rst), 32'h0);                         // Short break tolerated.
        i_host.hold(1'b0, 45);
        chk(32'(chip_rst), 32'h1);                         // Long break resets.
        i_host.hold(1'b1, 1);
        do_reset();
        $display("test break done");
        wr(`OFF_CTRL, 32'h20);                             // No link open at bypass.
        repeat (2) @(posedge ref_clk);
        chk(32'({sleep, gio_oe}), 32'h15);                 // Bypass and sleep.
        gio_i <= 4'hA;
        repeat (6) @(posedge ref_clk);
        chk(32'({tx, rts_n}), 32'h3);                      // Far lines passed on.
        gio_i <= 4'h0;
        i_host.hold(1'b0, 6);
        chk(32'({tx, gio_o[0], sleep}), 32'h1);            // Both ways, still asleep.
        i_host.hold(1'b1, 1);
        do_reset();
        chk(32'({sleep, gio_oe}), 32'h0);                  // Reset restores direct path.
        $display("test bypass done");
        summarize();
    end
endmodule : host_uart_with_bypass_test
